// ---- rtl/adc_serial_port.sv ----
// serial peripheral port, result read-out and calibration of the converter
module adc_serial_port #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    // serial pins
    input  wire logic                cs_n,
    input  wire logic                sclk,
    input  wire logic                din,
    output logic                     dout,
    output logic                     dout_oe,
    output logic                     conversion_ready_n,
    // filter result stream
    input  wire logic [31:0]         filt_data,
    input  wire logic                filt_valid,
    output logic                     filt_ready,
    // mode inputs
    input  wire logic                hpf_enable,
    input  wire logic                sinc_only,
    input  wire adc_port_pkg::vref_t vref_sel,
    // status
    output logic                     cal_busy
);
    import adc_port_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PULSE = 2'b01,
        ST_DIV   = 2'b10,
        ST_LOAD  = 2'b11
    } eng_t;

    typedef enum logic [1:0] {
        CAL_NONE  = 2'b00,
        CAL_ZERO  = 2'b01,
        CAL_SCALE = 2'b10
    } cal_t;

    // pin synchronisers, order {cs_n, sclk, din}
    logic [2:0]  pin_s1_ff;
    logic [2:0]  pin_s2_ff;
    logic [1:0]  pin_s3_ff;
    logic        cs_q;
    logic        din_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;

    // serial state
    logic [31:0] tx_sh_ff;
    logic [5:0]  tx_cnt_ff;
    logic        first_fall_ff;
    logic [6:0]  rx_sh_ff;
    logic [2:0]  rx_bits_ff;
    logic [1:0]  byte_idx_ff;
    logic [7:0]  op_ff;
    logic [3:0]  wr_addr_ff;
    logic [4:0]  wr_left_ff;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic        wr_en;

    // registers and engine
    logic [23:0] offset_ff;
    logic [23:0] gain_ff;
    logic [31:0] raw_ff;
    logic [31:0] out_word_ff;
    logic [31:0] corrected;
    eng_t        eng_ff;
    logic [3:0]  pulse_cnt_ff;
    cal_t        cal_ff;
    logic [6:0]  cal_cnt_ff;
    logic [23:0] quo_ff;
    logic [4:0]  div_bit_ff;
    logic [31:0] fifo_data;
    logic        fifo_valid;
    logic        pop;
    logic        cal_last;
    logic        cal_start;
    logic signed [32:0] den;
    logic [23:0] trial;
    logic [56:0] trial_prod;
    logic [56:0] target;

    assign cs_q      = pin_s2_ff[2];
    assign din_q     = pin_s2_ff[0];
    assign sclk_rise = pin_s2_ff[1] && !pin_s3_ff[0] && !cs_q;
    assign sclk_fall = !pin_s2_ff[1] && pin_s3_ff[0] && !cs_q;
    assign cs_fall   = !cs_q && pin_s3_ff[1];
    assign rx_byte   = {rx_sh_ff, din_q};
    assign byte_done = sclk_rise && rx_bits_ff == 3'h7;
    assign wr_en     = byte_done && byte_idx_ff == 2'h2 && op_ff[7:4] == CMD_WREG_OP
                       && wr_left_ff != '0;
    assign cal_start = byte_done && byte_idx_ff == 2'h0
                       && (rx_byte == CMD_ZERO_TRIM || rx_byte == CMD_SCALE_TRIM);
    assign pop       = eng_ff == ST_IDLE && fifo_valid && cs_q;
    assign cal_last  = cal_ff != CAL_NONE && cal_cnt_ff == CAL_CONVERSIONS - 7'h01;

    sample_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_data   (filt_data),
        .in_valid  (filt_valid),
        .in_ready  (filt_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop)
    );

    trim_datapath u_trim (
        .raw         (raw_ff),
        .offset_word (offset_ff),
        .gain_word   (gain_ff),
        .hpf_enable  (hpf_enable),
        .sinc_only   (sinc_only),
        .vref_sel    (vref_sel),
        .corrected   (corrected)
    );

    // two-stage sync, third stage only for edge finding
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pin_s1_ff <= 3'h4;
            pin_s2_ff <= 3'h4;
            pin_s3_ff <= 2'h2;
        end
        else if (ce)
        begin
            pin_s1_ff <= {cs_n, sclk, din};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff[2:1];
        end
    end

    // output shifter and pin drive
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            tx_sh_ff  <= '0;
            tx_cnt_ff <= '0;
            dout      <= 1'b0;
            dout_oe   <= 1'b0;
        end
        else if (ce)
        begin
            dout_oe <= !cs_q;
            if (cs_q)
            begin
                tx_cnt_ff <= '0;
                dout      <= 1'b0;
            end
            else if (cs_fall)
            begin
                tx_sh_ff  <= conversion_ready_n ? '0 : out_word_ff;
                dout      <= !conversion_ready_n && out_word_ff[31];
            end
            else if (sclk_fall)
            begin
                if (tx_cnt_ff < TX_WORD_BITS - 6'h01)
                    dout <= tx_sh_ff[30];
                else
                    dout <= 1'b0;
                tx_sh_ff <= {tx_sh_ff[30:0], 1'b0};
                if (tx_cnt_ff != TX_WORD_BITS)
                    tx_cnt_ff <= tx_cnt_ff + 6'h01;
            end
        end
    end

    // command byte capture
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rx_sh_ff    <= '0;
            rx_bits_ff  <= '0;
            byte_idx_ff <= '0;
            op_ff       <= '0;
            wr_addr_ff  <= '0;
            wr_left_ff  <= '0;
        end
        else if (ce)
        begin
            if (cs_q)
            begin
                rx_bits_ff  <= '0;
                byte_idx_ff <= '0;
                wr_left_ff  <= '0;
            end
            else if (sclk_rise)
            begin
                rx_sh_ff   <= rx_byte[6:0];
                rx_bits_ff <= rx_bits_ff + 3'h1;
                if (byte_done)
                begin
                    if (byte_idx_ff != 2'h2)
                        byte_idx_ff <= byte_idx_ff + 2'h1;
                    if (byte_idx_ff == 2'h0)
                    begin
                        op_ff      <= rx_byte;
                        wr_addr_ff <= rx_byte[3:0];
                    end
                    else if (byte_idx_ff == 2'h1)
                        wr_left_ff <= {1'b0, rx_byte[3:0]} + 5'h01;
                    else if (wr_en)
                    begin
                        wr_addr_ff <= wr_addr_ff + 4'h1;
                        wr_left_ff <= wr_left_ff - 5'h01;
                    end
                end
            end
        end
    end

    // offset and gain byte registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            offset_ff <= OFFSET_RESET;
            gain_ff   <= GAIN_UNITY;
        end
        else if (ce)
        begin
            if (pop && cal_last && cal_ff == CAL_ZERO)
                offset_ff <= fifo_data[31:8];
            else if (wr_en && wr_addr_ff == ADDR_OFS_LO)
                offset_ff[7:0] <= rx_byte;
            else if (wr_en && wr_addr_ff == ADDR_OFS_MID)
                offset_ff[15:8] <= rx_byte;
            else if (wr_en && wr_addr_ff == ADDR_OFS_HI)
                offset_ff[23:16] <= rx_byte;
            if (eng_ff == ST_DIV && div_bit_ff == 5'h0)
                gain_ff <= (trial_prod <= target) ? trial : quo_ff;
            else if (wr_en && wr_addr_ff == ADDR_GAIN_LO)
                gain_ff[7:0] <= rx_byte;
            else if (wr_en && wr_addr_ff == ADDR_GAIN_MID)
                gain_ff[15:8] <= rx_byte;
            else if (wr_en && wr_addr_ff == ADDR_GAIN_HI)
                gain_ff[23:16] <= rx_byte;
        end
    end

    // calibration sequencing
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cal_ff     <= CAL_NONE;
            cal_cnt_ff <= '0;
            cal_busy   <= 1'b0;
        end
        else if (ce)
        begin
            if (cal_start)
            begin
                cal_ff     <= (rx_byte == CMD_ZERO_TRIM) ? CAL_ZERO : CAL_SCALE;
                cal_cnt_ff <= '0;
                cal_busy   <= 1'b1;
            end
            else if (eng_ff == ST_LOAD)
            begin
                cal_ff   <= CAL_NONE;
                cal_busy <= 1'b0;
            end
            else if (pop && cal_ff != CAL_NONE && !cal_last)
                cal_cnt_ff <= cal_cnt_ff + 7'h01;
        end
    end

    // gain search: largest quotient with quotient times measured level within full scale
    assign den        = $signed({raw_ff[31], raw_ff}) - $signed({offset_ff[23], offset_ff, 8'h00});
    assign trial      = quo_ff | (24'h000001 << div_bit_ff);
    assign trial_prod = {1'b0, trial} * den[31:0];
    assign target     = {3'h0, fs_pos(sinc_only, vref_sel), 22'h000000};

    // result engine
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            eng_ff       <= ST_IDLE;
            raw_ff       <= '0;
            out_word_ff  <= '0;
            pulse_cnt_ff <= '0;
            quo_ff       <= '0;
            div_bit_ff   <= '0;
        end
        else if (ce)
        begin
            case (eng_ff)
                ST_IDLE:
                begin
                    pulse_cnt_ff <= '0;
                    quo_ff       <= '0;
                    div_bit_ff   <= 5'h17;
                    if (pop)
                    begin
                        raw_ff <= fifo_data;
                        if (cal_ff != CAL_NONE && !cal_last)
                            eng_ff <= ST_IDLE;
                        else if (cal_ff == CAL_SCALE)
                            eng_ff <= ST_DIV;
                        else if (cal_ff == CAL_NONE && !conversion_ready_n)
                            eng_ff <= ST_PULSE;
                        else
                            eng_ff <= ST_LOAD;
                    end
                end
                ST_PULSE:
                begin
                    pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
                    if (pulse_cnt_ff == READY_PULSE_CYCLES - 4'h2)
                        eng_ff <= ST_LOAD;
                end
                ST_DIV:
                begin
                    if (den[32] || den == '0)
                        eng_ff <= ST_LOAD;
                    else
                    begin
                        if (trial_prod <= target)
                            quo_ff <= trial;
                        div_bit_ff <= div_bit_ff - 5'h01;
                        if (div_bit_ff == 5'h0)
                            eng_ff <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    out_word_ff <= corrected;
                    eng_ff      <= ST_IDLE;
                end
                default:
                    eng_ff <= ST_IDLE;
            endcase
        end
    end

    // ready output, always driven but timed by chip select: fifo pops need it high, first-fall release needs it low
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            conversion_ready_n <= 1'b1;
            first_fall_ff      <= 1'b0;
        end
        else if (ce)
        begin
            first_fall_ff <= cs_q ? 1'b0 : (first_fall_ff || sclk_fall);
            if (eng_ff == ST_LOAD)
                conversion_ready_n <= 1'b0;
            else if (pop && cal_ff == CAL_NONE && !conversion_ready_n)
                conversion_ready_n <= 1'b1;
            else if (cal_start)
                conversion_ready_n <= 1'b1;
            else if (sclk_fall && !first_fall_ff)
                conversion_ready_n <= 1'b1;
        end
    end

    dout_hiz_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        cs_q |=> !dout_oe)
        else $error("data output driven while chip select high");

    msb_first_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        cs_fall && !conversion_ready_n |=> dout_oe && dout == $past(out_word_ff[31]))
        else $error("result msb not presented at chip select fall");

    ready_release_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        sclk_fall && !first_fall_ff && eng_ff != ST_LOAD |=> conversion_ready_n)
        else $error("ready not released on first falling clock");

    tail_low_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        !cs_q && tx_cnt_ff == TX_WORD_BITS |-> !dout)
        else $error("data output not low after full word");

    pulse_eight_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        $rose(conversion_ready_n) && eng_ff == ST_PULSE
        |-> conversion_ready_n [*8] ##1 !conversion_ready_n)
        else $error("unread result pulse not eight clocks");

    cal_hold_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        cal_busy && eng_ff != ST_LOAD |=> conversion_ready_n)
        else $error("ready fell during calibration");

    zero_trim_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        pop && cal_last && cal_ff == CAL_ZERO
        |=> offset_ff == $past(fifo_data[31:8]) ##1 !conversion_ready_n)
        else $error("offset calibration result not applied");

    gain_byte_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        wr_en && wr_addr_ff == ADDR_GAIN_HI && eng_ff != ST_DIV
        |=> gain_ff[23:16] == $past(rx_byte))
        else $error("top gain byte not from highest address");

    unity_pass_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        eng_ff == ST_LOAD && gain_ff == GAIN_UNITY && hpf_enable && !sinc_only
        |=> out_word_ff == $past(raw_ff))
        else $error("unity gain with offset bypass altered data");

    clip_range_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
        eng_ff == ST_LOAD |=> $signed(out_word_ff) <= $signed(fs_pos(sinc_only, vref_sel))
        && $signed(out_word_ff) >= $signed(fs_neg(sinc_only, vref_sel)))
        else $error("result outside full-scale range");
endmodule

// ---- rtl/adc_port_pkg.sv ----
// constants and helpers shared by the converter serial port and its calibration path
package adc_port_pkg;
    typedef enum logic [1:0] {
        VREF_2V5   = 2'b00,
        VREF_4V096 = 2'b01,
        VREF_5V    = 2'b10
    } vref_t;

    localparam int          WORD_BITS      = 32;
    localparam int          TRIM_BITS      = 24;
    localparam int          GAIN_SHIFT     = 22;
    localparam logic [23:0] GAIN_UNITY     = 24'h400000;
    localparam logic [23:0] OFFSET_RESET   = 24'h000000;
    localparam logic [7:0]  CMD_ZERO_TRIM  = 8'h60;
    localparam logic [7:0]  CMD_SCALE_TRIM = 8'h61;
    localparam logic [3:0]  CMD_WREG_OP    = 4'h4;
    localparam logic [3:0]  ADDR_OFS_LO    = 4'h1;
    localparam logic [3:0]  ADDR_OFS_MID   = 4'h2;
    localparam logic [3:0]  ADDR_OFS_HI    = 4'h3;
    localparam logic [3:0]  ADDR_GAIN_LO   = 4'h4;
    localparam logic [3:0]  ADDR_GAIN_MID  = 4'h5;
    localparam logic [3:0]  ADDR_GAIN_HI   = 4'h6;
    localparam logic [6:0]  CAL_CONVERSIONS    = 7'h51;
    localparam logic [3:0]  READY_PULSE_CYCLES = 4'h8;
    localparam logic [5:0]  TX_WORD_BITS       = 6'h20;

    // positive full-scale code for the active filter path
    function automatic logic [31:0] fs_pos(input logic sinc, input vref_t vref);
        logic [31:0] v;
        v = 32'h7fffffff;
        if (sinc && vref == VREF_5V)
            v = 32'h30000000;
        else if (sinc && vref == VREF_4V096)
            v = 32'h3a980000;
        else if (sinc)
            v = 32'h3fffffff;
        return v;
    endfunction

    // negative full-scale code for the active filter path
    function automatic logic [31:0] fs_neg(input logic sinc, input vref_t vref);
        logic [31:0] v;
        v = 32'h80000000;
        if (sinc && vref == VREF_5V)
            v = 32'hd0000000;
        else if (sinc && vref == VREF_4V096)
            v = 32'hc5680000;
        else if (sinc)
            v = 32'hc0000000;
        return v;
    endfunction
endpackage

// ---- rtl/sample_fifo.sv ----
// flip-flop fifo between the filter stream and the output stage
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = cnt_ff != '0;
    assign out_data  = mem_ff[rd_ff];
    assign nxt_cnt   = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem_ff[wr_ff] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wr_ff    <= '0;
            rd_ff    <= '0;
            cnt_ff   <= '0;
            in_ready <= 1'b0;
        end
        else if (ce)
        begin
            if (push)
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            if (pop)
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            cnt_ff   <= nxt_cnt;
            in_ready <= nxt_cnt != (AW + 1)'(DEPTH);
        end
    end
endmodule

// ---- rtl/trim_datapath.sv ----
// offset subtraction, gain scaling and clipping of one filter result
module trim_datapath (
    // operands
    input  wire logic [31:0]         raw,
    input  wire logic [23:0]         offset_word,
    input  wire logic [23:0]         gain_word,
    // modes
    input  wire logic                hpf_enable,
    input  wire logic                sinc_only,
    input  wire adc_port_pkg::vref_t vref_sel,
    // result
    output logic [31:0]              corrected
);
    import adc_port_pkg::*;

    logic signed [32:0] diff;
    logic signed [57:0] prod;
    logic signed [35:0] scaled;
    logic signed [35:0] lim_hi;
    logic signed [35:0] lim_lo;

    always_comb
    begin
        if (hpf_enable)
            diff = {raw[31], raw};
        else
            diff = $signed({raw[31], raw}) - $signed({offset_word[23], offset_word, 8'h00});
        prod   = diff * $signed({1'b0, gain_word});
        scaled = prod[57:GAIN_SHIFT];
        lim_hi = $signed({{4{1'b0}}, fs_pos(sinc_only, vref_sel)});
        lim_lo = $signed({{4{1'b1}}, fs_neg(sinc_only, vref_sel)});
        if (scaled > lim_hi)
            corrected = lim_hi[31:0];
        else if (scaled < lim_lo)
            corrected = lim_lo[31:0];
        else
            corrected = scaled[31:0];
    end
endmodule

// ---- tb/spi_host_model.sv ----
// host controller model that frames commands and reads results in mode 0
module spi_host_model (
    // serial pins
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end
    // one frame: n bits out msb first, last 32 bits in, level after the last fall
    task automatic frame(input logic [63:0] tx, input int n, output logic [31:0] rx,
                         output logic tail);
        rx = '0;
        cs_n = 1'b0;
        #800;
        for (int i = 0; i < n; i++)
        begin
            din = tx[63-i];
            #400 sclk = 1'b1;
            rx = {rx[30:0], miso};
            #400 sclk = 1'b0;
        end
        #400 tail = miso;
        cs_n = 1'b1;
        din = 1'b0;
        #1600;
    endtask
endmodule

// ---- tb/adc_serial_port_tb_top.sv ----
// self-checking bench for the converter serial port
module adc_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_port_pkg::*;
    logic        clk, rstn, ce, filt_valid, hpf_enable, sinc_only;
    logic        dout, dout_oe, rdy_n, filt_ready, cal_busy, tail;
    logic [31:0] filt_data, rx;
    vref_t       vref_sel;
    wire         cs_n, sclk, din, miso;
    int          fail_count = 0;
    int          n_checks = 0;
    assign miso = dout_oe ? dout : 1'bz;
    spi_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din), .miso(miso));
    adc_serial_port #(.FIFO_DEPTH(8)) DUT (.clk(clk), .rstn(rstn), .ce(ce), .cs_n(cs_n),
        .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe), .conversion_ready_n(rdy_n),
        .filt_data(filt_data), .filt_valid(filt_valid), .filt_ready(filt_ready),
        .hpf_enable(hpf_enable), .sinc_only(sinc_only), .vref_sel(vref_sel),
        .cal_busy(cal_busy));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        fail_count++;
        $display("BAD t=%0t got %h exp %h", $time, 0, 1);
        report_and_stop();
    endtask
    task automatic push(input logic [31:0] w);
        int k;
        k = 0;
        @(posedge clk);
        filt_data <= w;
        filt_valid <= 1'b1;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (filt_ready !== 1'b1 && k < 200);
        if (k >= 200)
            timeout();
        @(posedge clk);
        filt_valid <= 1'b0;
    endtask
    task automatic wait_rdy(input int bound);
        int k;
        k = 0;
        while (rdy_n !== 1'b0 && k < bound)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= bound)
            timeout();
    endtask
    task automatic rd(input logic [31:0] w, input int n, input logic [31:0] exp);
        push(w);
        wait_rdy(100);
        host.frame(64'h0, n, rx, tail);
        check(rx, exp);
    endtask
    task automatic t_read();
        int k;
        rd(32'h81234567, 32, 32'h81234567);
        check({31'h0, tail}, 32'h0);
        check({31'h0, rdy_n}, 32'h1);
        check({31'h0, miso}, {31'h0, 1'bz});
        rd(32'h12345678, 24, 32'h00123456);
        rd(32'h7edcba98, 32, 32'h7edcba98);
        push(32'h00000100);
        wait_rdy(100);
        push(32'h00000200);
        k = 0;
        while (rdy_n !== 1'b1 && k < 20)
        begin
            @(negedge clk);
            k++;
        end
        k = 0;
        while (rdy_n === 1'b1 && k < 20)
        begin
            @(negedge clk);
            k++;
        end
        check(k, 32'h8);
        host.frame(64'h0, 32, rx, tail);
        check(rx, 32'h00000200);
        $display("read test done");
    endtask
    task automatic t_manual();
        logic [31:0] acc;
        for (int i = 0; i < 64; i++)
            push(32'h00001180);
        repeat (120) @(negedge clk);
        host.frame(64'h0, 32, rx, tail);
        rd(32'h00001100, 32, 32'h00001100);
        acc = rx;
        rd(32'h00001300, 32, 32'h00001300);
        acc = (acc + rx) >> 1;
        host.frame({8'h41, 8'h02, acc[15:8], acc[23:16], acc[31:24], 24'h0}, 40, rx, tail);
        rd(32'h00001234, 32, 32'h00000034);
        $display("manual calibration test done");
    endtask
    task automatic cal(input logic [7:0] cmd, input logic [31:0] w, input logic [31:0] exp);
        host.frame({cmd, 56'h0}, 8, rx, tail);
        repeat (4) @(negedge clk);
        check({31'h0, cal_busy}, 32'h1);
        for (int i = 0; i < 81; i++)
            push(w);
        wait_rdy(400);
        check({31'h0, cal_busy}, 32'h0);
        host.frame(64'h0, 32, rx, tail);
        check(rx, exp);
    endtask
    task automatic t_cal();
        host.frame(64'h4105000000000040, 64, rx, tail);
        @(posedge clk);
        hpf_enable <= 1'b0;
        @(negedge clk);
        cal(CMD_ZERO_TRIM, 32'h00001234, 32'h00000034);
        cal(CMD_SCALE_TRIM, 32'h400011ff, 32'h7ffffffe);
        $display("calibration test done");
    endtask
    task automatic t_trim();
        host.frame(64'h4402000020000000, 40, rx, tail);
        rd(32'h10001000, 32, 32'h07ffff00);
        @(posedge clk);
        hpf_enable <= 1'b1;
        rd(32'h10001000, 32, 32'h08000800);
        @(posedge clk);
        sinc_only <= 1'b1;
        vref_sel <= VREF_4V096;
        rd(32'h7ffffff0, 32, 32'h3a980000);
        host.frame(64'h4600400000000000, 24, rx, tail);
        @(posedge clk);
        sinc_only <= 1'b0;
        rd(32'h12345678, 32, 32'h12345678);
        $display("trim test done");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        filt_valid = 1'b0;
        filt_data = 32'h0;
        hpf_enable = 1'b0;
        sinc_only = 1'b0;
        vref_sel = VREF_2V5;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        t_read();
        t_manual();
        t_cal();
        t_trim();
        report_and_stop();
    end
endmodule
